// ==== src/rdp_pkg.sv ====
// Shared constants, types and helpers of the readout result port
package rdp_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int RDP_CLK_NS = 20;
    localparam int RDP_WORD_NS = 40;
    localparam int RDP_WORD_CYC = (RDP_WORD_NS + RDP_CLK_NS - 1) / RDP_CLK_NS;
    localparam int RDP_DECIM_DEFAULT = 5625000;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] RDP_OFS_MODE = 8'h00;
    localparam logic [7:0] RDP_OFS_DRIVE = 8'h04;
    localparam logic [7:0] RDP_OFS_OUTVAL = 8'h08;
    localparam logic [7:0] RDP_OFS_INVAL = 8'h0C;
    localparam logic [7:0] RDP_OFS_CLKSEL = 8'h10;
    localparam logic [7:0] RDP_OFS_DECIM = 8'h14;
    localparam logic [7:0] RDP_OFS_OVF = 8'h18;
    localparam logic [7:0] RDP_OFS_LINK = 8'h1C;
    // ------------------------------------------------------------
    // Modes, reset values and field positions
    // ------------------------------------------------------------
    localparam logic [1:0] RDP_MODE_MANUAL = 2'h0;
    localparam logic [1:0] RDP_MODE_SEQ = 2'h1;
    localparam logic [1:0] RDP_MODE_RESULT = 2'h2;
    localparam logic [1:0] RDP_MODE_RST = 2'h0;
    localparam logic [3:0] RDP_DRIVE_RST = 4'h0;
    localparam logic [31:0] RDP_OUTVAL_RST = 32'h0;
    localparam logic RDP_CLKSEL_RST = 1'b0;
    localparam int RDP_RES_VALID_BIT = 0;
    localparam int RDP_RES_CHAN_LSB = 1;
    localparam int RDP_RES_DATA_LSB = 8;
    localparam int RDP_INPUT_LANE = 3;
    localparam int RDP_OVF_LIVE_BIT = 0;
    localparam int RDP_OVF_STICKY_BIT = 1;
    localparam logic [1:0] RDP_MSG_ADDR = 2'h1;
    localparam logic [1:0] RDP_MSG_MASK = 2'h2;
    localparam logic [1:0] RDP_MSG_DATA = 2'h3;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] kind;
        logic [31:0] payload;
    } rdp_msg_s;
    typedef struct packed {
        logic [3:0] chan;
        logic [15:0] bits;
    } rdp_result_s;
    typedef enum logic [4:0] {
        RDP_S_IDLE = 5'b00001,
        RDP_S_ADDR = 5'b00010,
        RDP_S_MASK = 5'b00100,
        RDP_S_WAIT = 5'b01000,
        RDP_S_DATA = 5'b10000
    } rdp_tx_state_e;
    // Expands one drive bit per lane into a 32-bit line mask
    function automatic logic [31:0] rdp_lane_mask(input logic [3:0] drive);
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{drive[i]}};
        end
        return m;
    endfunction : rdp_lane_mask
endpackage : rdp_pkg

// ==== src/rdp_msg_sender.sv ====
// Sends each readout to the system controller as address, mask and data messages
`timescale 1ns/1ps
module rdp_msg_sender (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [31:0] addr,
    input wire logic [31:0] mask,
    input wire logic res_valid,
    input wire rdp_pkg::rdp_result_s res,
    input wire logic link_ready,
    output logic msg_valid,
    output rdp_pkg::rdp_msg_s msg,
    output logic busy
);
    rdp_pkg::rdp_tx_state_e state_r;
    rdp_pkg::rdp_msg_s msg_r;
    rdp_pkg::rdp_result_s pend_res_r;
    logic [31:0] mask_r;
    logic valid_r;
    logic pend_r;
    logic [31:0] data_word;

    // The first result that lands while address or mask are still queued is held
    assign data_word = pend_r ? 32'({pend_res_r.chan, pend_res_r.bits})
                              : 32'({res.chan, res.bits});

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= rdp_pkg::RDP_S_IDLE;
            valid_r <= 1'b0;
            msg_r <= '0;
            mask_r <= 32'h0;
        end else begin
            unique case (state_r)
                rdp_pkg::RDP_S_IDLE: begin
                    if (start) begin
                        msg_r <= '{kind: rdp_pkg::RDP_MSG_ADDR, payload: addr};
                        mask_r <= mask;
                        valid_r <= 1'b1;
                        state_r <= rdp_pkg::RDP_S_ADDR;
                    end
                end
                rdp_pkg::RDP_S_ADDR: begin
                    if (link_ready) begin
                        msg_r <= '{kind: rdp_pkg::RDP_MSG_MASK, payload: mask_r};
                        state_r <= rdp_pkg::RDP_S_MASK;
                    end
                end
                rdp_pkg::RDP_S_MASK: begin
                    if (link_ready && (pend_r || res_valid)) begin
                        msg_r <= '{kind: rdp_pkg::RDP_MSG_DATA, payload: data_word};
                        state_r <= rdp_pkg::RDP_S_DATA;
                    end else if (link_ready) begin
                        valid_r <= 1'b0;
                        state_r <= rdp_pkg::RDP_S_WAIT;
                    end
                end
                rdp_pkg::RDP_S_WAIT: begin
                    if (res_valid) begin
                        msg_r <= '{kind: rdp_pkg::RDP_MSG_DATA, payload: data_word};
                        valid_r <= 1'b1;
                        state_r <= rdp_pkg::RDP_S_DATA;
                    end
                end
                rdp_pkg::RDP_S_DATA: begin
                    if (link_ready) begin
                        valid_r <= 1'b0;
                        state_r <= rdp_pkg::RDP_S_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pend_r <= 1'b0;
            pend_res_r <= '0;
        end else if (state_r == rdp_pkg::RDP_S_IDLE) begin
            pend_r <= 1'b0;
        end else if (res_valid && !pend_r
                     && (state_r == rdp_pkg::RDP_S_ADDR || state_r == rdp_pkg::RDP_S_MASK)) begin
            pend_r <= 1'b1;
            pend_res_r <= res;
        end
    end

    assign msg_valid = valid_r;
    assign msg = msg_r;
    assign busy = (state_r != rdp_pkg::RDP_S_IDLE);

    sequence s_addr_taken;
        valid_r && msg_r.kind == rdp_pkg::RDP_MSG_ADDR && link_ready;
    endsequence
    sequence s_mask_taken;
        valid_r && msg_r.kind == rdp_pkg::RDP_MSG_MASK && link_ready;
    endsequence

    a_start_sends_addr: assert property (@(posedge clk) disable iff (reset)
        start && state_r == rdp_pkg::RDP_S_IDLE |=> valid_r && msg_r.kind == rdp_pkg::RDP_MSG_ADDR)
        else $error("start did not raise an address message");
    a_mask_follows_addr: assert property (@(posedge clk) disable iff (reset)
        s_addr_taken |=> valid_r && msg_r.kind == rdp_pkg::RDP_MSG_MASK && msg_r.payload == mask_r)
        else $error("mask message did not follow address");
    a_data_after_mask: assert property (@(posedge clk) disable iff (reset)
        s_mask_taken |=> (!valid_r && state_r == rdp_pkg::RDP_S_WAIT)
                         || (valid_r && msg_r.kind == rdp_pkg::RDP_MSG_DATA))
        else $error("data message out of order");
    a_data_immediate: assert property (@(posedge clk) disable iff (reset)
        state_r == rdp_pkg::RDP_S_WAIT && res_valid
        |=> valid_r && msg_r.kind == rdp_pkg::RDP_MSG_DATA
            && msg_r.payload == 32'({$past(res.chan), $past(res.bits)}))
        else $error("data message not sent at once");
    a_msg_held_stalled: assert property (@(posedge clk) disable iff (reset)
        valid_r && !link_ready |=> valid_r && $stable(msg_r))
        else $error("message changed while stalled");
endmodule : rdp_msg_sender

// ==== src/rdp_input_sampler.sv ====
// Synchronises the port inputs and the external clock and decimates the input samples
`timescale 1ns/1ps
module rdp_input_sampler (
    input wire logic clk,
    input wire logic reset,
    input wire logic ext_clk_pin,
    input wire logic use_ext,
    input wire logic [31:0] decim,
    input wire logic [31:0] pins_in,
    output logic [31:0] sample,
    output logic sample_tick
);
    logic [2:0] eclk_sync_r;
    logic eclk_filt_r;
    logic [31:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_filt_r;
    logic [31:0] count_r;
    logic [31:0] sample_r;
    logic tick_r;
    logic eclk_rise;
    logic clk_tick;

    // Three stages; a change counts only when stages two and three agree
    always_ff @(posedge clk) begin
        if (reset) begin
            eclk_sync_r <= 3'h0;
            eclk_filt_r <= 1'b0;
            pin_s1_r <= 32'h0;
            pin_s2_r <= 32'h0;
            pin_s3_r <= 32'h0;
            pin_filt_r <= 32'h0;
        end else begin
            eclk_sync_r <= {eclk_sync_r[1:0], ext_clk_pin};
            if (eclk_sync_r[1] == eclk_sync_r[2]) begin
                eclk_filt_r <= eclk_sync_r[2];
            end
            pin_s1_r <= pins_in;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_filt_r <= (pin_s2_r & pin_s3_r) | (pin_filt_r & (pin_s2_r ^ pin_s3_r));
        end
    end

    assign eclk_rise = (eclk_sync_r[1] == eclk_sync_r[2]) && eclk_sync_r[2] && !eclk_filt_r;
    assign clk_tick = use_ext ? eclk_rise : 1'b1;

    always_ff @(posedge clk) begin
        if (reset) begin
            count_r <= 32'h0;
            sample_r <= 32'h0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (clk_tick) begin
                if (count_r + 32'h1 >= decim) begin
                    count_r <= 32'h0;
                    sample_r <= pin_filt_r;
                    tick_r <= 1'b1;
                end else begin
                    count_r <= count_r + 32'h1;
                end
            end
        end
    end

    assign sample = sample_r;
    assign sample_tick = tick_r;
endmodule : rdp_input_sampler

// ==== src/rdp_top.sv ====
// Readout result port: 32-line parallel port, overflow tracking and result link sender
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module rdp_top #(
    parameter logic [31:0] DECIM_DEFAULT = 32'(rdp_pkg::RDP_DECIM_DEFAULT)
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    input wire logic readout_start_command,
    input wire logic [31:0] readout_address,
    input wire logic [31:0] readout_mask,
    input wire logic result_valid,
    input wire rdp_pkg::rdp_result_s result,
    input wire logic seq_port_strobe,
    input wire logic [31:0] seq_port_value,
    input wire logic link_ready,
    output logic link_msg_valid,
    output rdp_pkg::rdp_msg_s link_msg,
    input wire logic [31:0] parallel_io_port_in,
    output logic [31:0] parallel_io_port_out,
    output logic [31:0] parallel_io_port_oe,
    input wire logic external_sample_clock_pin,
    output logic sample_clock_out_pin
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0] mode_r;
    logic [3:0] drive_r;
    logic [31:0] outval_r;
    logic clksel_r;
    logic [31:0] decim_r;
    logic [31:0] seqval_r;
    logic [31:0] rdata_r;
    logic [31:0] res_word_r;
    logic [7:0] word_cnt_r;
    logic ovf_live_r;
    logic ovf_sticky_r;
    logic [31:0] pin_out_r;
    logic [31:0] pin_oe_r;
    logic clk_pos_r;
    logic clk_neg_r;
    logic [31:0] out_nxt;
    logic [3:0] lane_drive;
    logic [31:0] in_sample;
    logic link_busy;
    logic result_mode;
    logic ovf_event;
    logic res_load;
    logic sticky_clear;

    assign result_mode = (mode_r == rdp_pkg::RDP_MODE_RESULT);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_r <= rdp_pkg::RDP_MODE_RST;
            drive_r <= rdp_pkg::RDP_DRIVE_RST;
            outval_r <= rdp_pkg::RDP_OUTVAL_RST;
            clksel_r <= rdp_pkg::RDP_CLKSEL_RST;
            decim_r <= DECIM_DEFAULT;
        end else if (reg_we) begin
            unique case (reg_addr)
                rdp_pkg::RDP_OFS_MODE: mode_r <= reg_wdata[1:0];
                rdp_pkg::RDP_OFS_DRIVE: drive_r <= reg_wdata[3:0];
                rdp_pkg::RDP_OFS_OUTVAL: outval_r <= reg_wdata;
                rdp_pkg::RDP_OFS_CLKSEL: clksel_r <= reg_wdata[0];
                rdp_pkg::RDP_OFS_DECIM: decim_r <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    assign sticky_clear = reg_we && (reg_addr == rdp_pkg::RDP_OFS_OVF)
                          && reg_wdata[rdp_pkg::RDP_OVF_STICKY_BIT];

    // ------------------------------------------------------------
    // Register reads, data one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_r <= 32'h0;
        end else if (reg_re) begin
            unique case (reg_addr)
                rdp_pkg::RDP_OFS_MODE: rdata_r <= 32'(mode_r);
                rdp_pkg::RDP_OFS_DRIVE: rdata_r <= 32'(drive_r);
                rdp_pkg::RDP_OFS_OUTVAL: rdata_r <= outval_r;
                rdp_pkg::RDP_OFS_INVAL: rdata_r <= in_sample;
                rdp_pkg::RDP_OFS_CLKSEL: rdata_r <= 32'(clksel_r);
                rdp_pkg::RDP_OFS_DECIM: rdata_r <= decim_r;
                rdp_pkg::RDP_OFS_OVF: rdata_r <= 32'({ovf_sticky_r, ovf_live_r});
                rdp_pkg::RDP_OFS_LINK: rdata_r <= 32'(link_busy);
                default: rdata_r <= 32'h0;
            endcase
        end else begin
            rdata_r <= 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer-set port value
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            seqval_r <= 32'h0;
        end else if (seq_port_strobe) begin
            seqval_r <= seq_port_value;
        end
    end

    // ------------------------------------------------------------
    // Result word engine and overflow
    // ------------------------------------------------------------
    // A word is held for a fixed number of cycles; results arriving
    // meanwhile are dropped, as the port cannot carry them.
    assign res_load = result_mode && result_valid && (word_cnt_r == 8'h0);
    assign ovf_event = result_mode && result_valid && (word_cnt_r != 8'h0);

    always_ff @(posedge clk) begin
        if (reset) begin
            res_word_r <= 32'h0;
            word_cnt_r <= 8'h0;
        end else if (res_load) begin
            res_word_r <= 32'h0;
            res_word_r[rdp_pkg::RDP_RES_VALID_BIT] <= 1'b1;
            res_word_r[rdp_pkg::RDP_RES_CHAN_LSB +: 4] <= result.chan;
            res_word_r[rdp_pkg::RDP_RES_DATA_LSB +: 16] <= result.bits;
            word_cnt_r <= 8'(rdp_pkg::RDP_WORD_CYC);
        end else if (word_cnt_r != 8'h0) begin
            word_cnt_r <= word_cnt_r - 8'h1;
            if (word_cnt_r == 8'h1) begin
                res_word_r <= 32'h0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ovf_live_r <= 1'b0;
        end else if (ovf_event) begin
            ovf_live_r <= 1'b1;
        end else if (word_cnt_r == 8'h0 || !result_mode) begin
            ovf_live_r <= 1'b0;
        end
    end

    // The set wins over a clear written in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            ovf_sticky_r <= 1'b0;
        end else if (ovf_event) begin
            ovf_sticky_r <= 1'b1;
        end else if (sticky_clear) begin
            ovf_sticky_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Port output selection
    // ------------------------------------------------------------
    always_comb begin
        lane_drive = drive_r;
        if (result_mode) begin
            lane_drive[rdp_pkg::RDP_INPUT_LANE] = 1'b0;
        end
        unique case (mode_r)
            rdp_pkg::RDP_MODE_SEQ: out_nxt = seqval_r;
            rdp_pkg::RDP_MODE_RESULT: out_nxt = res_word_r;
            default: out_nxt = outval_r;
        endcase
        out_nxt = out_nxt & rdp_pkg::rdp_lane_mask(lane_drive);
    end

    // Outputs change half a cycle after logic settles, leaving the
    // far side a full rising edge of the sample clock to capture them.
    always_ff @(negedge clk) begin
        if (reset) begin
            pin_out_r <= 32'h0;
            pin_oe_r <= 32'h0;
        end else begin
            pin_out_r <= out_nxt;
            pin_oe_r <= rdp_pkg::rdp_lane_mask(lane_drive);
        end
    end

    // ------------------------------------------------------------
    // Sample clock forwarded to its pin
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            clk_pos_r <= 1'b0;
        end else begin
            clk_pos_r <= !clk_pos_r;
        end
    end

    always_ff @(negedge clk) begin
        if (reset) begin
            clk_neg_r <= 1'b0;
        end else begin
            clk_neg_r <= clk_pos_r;
        end
    end

    // High from each rising edge to the next falling edge
    assign sample_clock_out_pin = clk_pos_r ^ clk_neg_r;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    rdp_input_sampler u_sampler (
        .clk(clk),
        .reset(reset),
        .ext_clk_pin(external_sample_clock_pin),
        .use_ext(clksel_r),
        .decim(decim_r),
        .pins_in(parallel_io_port_in),
        .sample(in_sample),
        .sample_tick()
    );

    rdp_msg_sender u_sender (
        .clk(clk),
        .reset(reset),
        .start(readout_start_command),
        .addr(readout_address),
        .mask(readout_mask),
        .res_valid(result_valid),
        .res(result),
        .link_ready(link_ready),
        .msg_valid(link_msg_valid),
        .msg(link_msg),
        .busy(link_busy)
    );

    assign reg_rdata = rdata_r;
    assign parallel_io_port_out = pin_out_r;
    assign parallel_io_port_oe = pin_oe_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_ovf_live_set: assert property (@(posedge clk) disable iff (reset)
        ovf_event |=> ovf_live_r && ovf_sticky_r)
        else $error("overflow did not raise the flags");
    a_ovf_on_busy: assert property (@(posedge clk) disable iff (reset)
        result_mode && result_valid && word_cnt_r != 8'h0 |=> ovf_live_r)
        else $error("busy port result not flagged");
    a_no_ovf_idle: assert property (@(posedge clk) disable iff (reset)
        !ovf_live_r && (word_cnt_r == 8'h0) && !ovf_event |=> !ovf_live_r)
        else $error("overflow raised without cause");
    a_sticky_holds: assert property (@(posedge clk) disable iff (reset)
        ovf_sticky_r && !sticky_clear |=> ovf_sticky_r)
        else $error("sticky overflow lost");
    a_sticky_clear: assert property (@(posedge clk) disable iff (reset)
        sticky_clear && !ovf_event |=> !ovf_sticky_r)
        else $error("sticky overflow not cleared");
    a_result_word: assert property (@(posedge clk) disable iff (reset)
        res_load |=> res_word_r[0] && res_word_r[4:1] == $past(result.chan)
                     && res_word_r[23:8] == $past(result.bits) ##2 res_word_r == 32'h0)
        else $error("result word wrong or held wrong");
    a_input_lane_off: assert property (@(negedge clk) disable iff (reset)
        result_mode |=> pin_oe_r[31:24] == 8'h00)
        else $error("input lane driven in result mode");
    a_undriven_quiet: assert property (@(negedge clk) disable iff (reset)
        ##1 (pin_out_r & ~pin_oe_r) == 32'h0)
        else $error("value on undriven line");
    a_read_latency: assert property (@(posedge clk) disable iff (reset)
        reg_re && reg_addr == rdp_pkg::RDP_OFS_INVAL |=> rdata_r == $past(in_sample))
        else $error("input read wrong");
endmodule : rdp_top

// ==== tb/rdp_link_partner.sv ====
// Behavioural model of the system controller on the result link
`timescale 1ns/1ps
module rdp_link_partner (
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic link_msg_valid,
    input wire rdp_pkg::rdp_msg_s link_msg,
    output logic link_ready,
    output logic [31:0] bank_addr,
    output logic [31:0] bank_data,
    output logic order_bad
);
    logic [1:0] last_r;
    always_ff @(posedge clk) begin
        if (reset) begin
            link_ready <= 1'b0;
            last_r <= 2'h0;
            order_bad <= 1'b0;
            bank_addr <= 32'h0;
            bank_data <= 32'h0;
        end else begin
            // Slow mode stalls every other cycle to stretch each message
            link_ready <= !slow || !link_ready;
            if (link_msg_valid && link_ready) begin
                last_r <= link_msg.kind;
                if (link_msg.kind != ((last_r == 2'h3 || last_r == 2'h0) ? 2'h1 : last_r + 2'h1))
                    order_bad <= 1'b1;
                if (link_msg.kind == rdp_pkg::RDP_MSG_ADDR)
                    bank_addr <= link_msg.payload;
                if (link_msg.kind == rdp_pkg::RDP_MSG_DATA)
                    bank_data <= link_msg.payload;
            end
        end
    end
endmodule : rdp_link_partner

// ==== tb/rdp_top_tb_top.sv ====
// Self-checking bench of the readout result port
`timescale 1ns/1ps
module rdp_top_tb_top;
    logic clk, reset, reg_we, reg_re, start, res_v, strobe, slow, msg_v, ready, order_bad;
    logic eclk, clk_out;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, seq_val, ro_addr, bank_addr, bank_data;
    rdp_pkg::rdp_result_s res;
    rdp_pkg::rdp_msg_s msg;
    int miscompares = 0;
    int checked = 0;
    typedef struct {logic [31:0] drive, val, out, oe;} rdp_row_s;
    rdp_row_s rows[3] = '{'{32'h1, 32'hA5A55A5A, 32'h0000005A, 32'h000000FF},
        '{32'hA, 32'hA5A55A5A, 32'hA5005A00, 32'hFF00FF00},
        '{32'hF, 32'h0F0F0F0F, 32'h0F0F0F0F, 32'hFFFFFFFF}};
    rdp_top #(.DECIM_DEFAULT(32'h4)) i_rdp_top (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .readout_start_command(start), .readout_address(ro_addr), .readout_mask(32'hFF),
        .result_valid(res_v), .result(res), .seq_port_strobe(strobe), .seq_port_value(seq_val),
        .link_ready(ready), .link_msg_valid(msg_v), .link_msg(msg), .parallel_io_port_in(pin_in),
        .parallel_io_port_out(pin_out), .parallel_io_port_oe(pin_oe),
        .external_sample_clock_pin(eclk), .sample_clock_out_pin(clk_out));
    rdp_link_partner i_rdp_link_partner (.clk(clk), .reset(reset), .slow(slow),
        .link_msg_valid(msg_v), .link_msg(msg), .link_ready(ready), .bank_addr(bank_addr),
        .bank_data(bank_data), .order_bad(order_bad));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic give_verdict();
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_we} <= {a, d, 1'b1};
        @(posedge clk);
        reg_we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        {reg_addr, reg_re} <= {a, 1'b1};
        @(posedge clk);
        reg_re <= 1'b0;
        @(negedge clk);
        check("reg_rdata", reg_rdata, exp);
    endtask : rd
    task automatic pulse_result();
        @(posedge clk);
        res_v <= 1'b1;
        @(posedge clk);
        res_v <= 1'b0;
    endtask : pulse_result
    initial begin
        {reset, reg_we, reg_re, start, res_v, strobe, slow, eclk} = 8'h80;
        {reg_addr, reg_wdata, seq_val, pin_in, ro_addr} = '0;
        res = {4'h2, 16'hBEEF};
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(rdp_pkg::RDP_OFS_MODE, 32'h0);
        rd(rdp_pkg::RDP_OFS_DECIM, 32'h4);
        rd(8'h20, 32'h0);
        foreach (rows[i]) begin
            wr(rdp_pkg::RDP_OFS_DRIVE, rows[i].drive);
            wr(rdp_pkg::RDP_OFS_OUTVAL, rows[i].val);
            repeat (2) @(posedge clk);
            @(negedge clk);
            check("pins", pin_out, rows[i].out);
            check("drive", pin_oe, rows[i].oe);
        end
        pin_in <= 32'hC3C33C3C;
        repeat (30) @(posedge clk);
        rd(rdp_pkg::RDP_OFS_INVAL, 32'hC3C33C3C);
        wr(rdp_pkg::RDP_OFS_MODE, 32'h1);
        {strobe, seq_val} <= {1'b1, 32'h12345678};
        @(posedge clk);
        strobe <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("seq pins", pin_out, 32'h12345678);
        // Mid-phase looks keep clear of the edges that move the clock copy
        @(posedge clk);
        #5 check("clk out high", {31'h0, clk_out}, 32'h1);
        #10 check("clk out low", {31'h0, clk_out}, 32'h0);
        wr(rdp_pkg::RDP_OFS_MODE, 32'h2);
        wr(rdp_pkg::RDP_OFS_DRIVE, 32'h7);
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            {slow, start, ro_addr, res} <= {s[0], 1'b1, 32'h10 + s, 4'h2, 16'hBEEF + 16'(s)};
            @(posedge clk);
            start <= 1'b0;
            repeat (6) @(posedge clk);
            check("early addr", bank_addr, 32'h10 + s);
            pulse_result();
            for (int w = 0; w < 20 && pin_out[0] !== 1'b1; w++)
                @(negedge clk);
            check("result word", pin_out, 32'h00BEEF05 + (32'(s) << 8));
            check("result drive", pin_oe, 32'h00FFFFFF);
            repeat (20) @(posedge clk);
            check("data", bank_data, 32'h0002BEEF + 32'(s));
            check("order", {31'h0, order_bad}, 32'h0);
        end
        pulse_result();
        pulse_result();
        repeat (10) @(posedge clk);
        rd(rdp_pkg::RDP_OFS_OVF, 32'h2);
        wr(rdp_pkg::RDP_OFS_OVF, 32'h2);
        rd(rdp_pkg::RDP_OFS_OVF, 32'h0);
        // External clock: no edges means no new sample, then five rises give one
        wr(rdp_pkg::RDP_OFS_CLKSEL, 32'h1);
        pin_in <= 32'h5A5A0000;
        repeat (30) @(posedge clk);
        rd(rdp_pkg::RDP_OFS_INVAL, 32'hC3C33C3C);
        repeat (10) begin
            repeat (4) @(posedge clk);
            eclk <= ~eclk;
        end
        repeat (10) @(posedge clk);
        rd(rdp_pkg::RDP_OFS_INVAL, 32'h5A5A0000);
        give_verdict();
    end
endmodule : rdp_top_tb_top
